// >>> common/sdr_consts.svh
`ifndef SDR_CONSTS_SVH
`define SDR_CONSTS_SVH

// Bus widths
`define SDR_ADDR_W        8
`define SDR_DATA_W        8

// Register offsets
`define SDR_OFS_CTRL      8'h6E
`define SDR_OFS_STAT      8'h70
`define SDR_OFS_CLR       8'h71
`define SDR_OFS_EN        8'h72

// Control/status register layout and reset value
`define SDR_CTRL_RESET    8'h38
`define SDR_BIT_SUP_FLAG  7
`define SDR_BIT_WDT_FLAG  6
`define SDR_RSV_HI        5
`define SDR_RSV_LO        3
`define SDR_RSV_VALUE     3'h7
`define SDR_BIT_WDT_CLR   0

// Interrupt status/clear/enable layout
`define SDR_IRQ_W         3
`define SDR_IRQ_SUP       0
`define SDR_IRQ_WDT       1
`define SDR_IRQ_WARN      2

// Watchdog counter
`define SDR_WDT_W         20
`define SDR_WDT_LIMIT     20'hFFFFF

// Internal reset hold time, 4 ns clock period
`define SDR_CLK_PS        4000
`define SDR_HOLD_NS       100
`define SDR_HOLD_CYC ((`SDR_HOLD_NS * 1000 + `SDR_CLK_PS - 1) / `SDR_CLK_PS)
`define SDR_HOLD_W        8

`endif

// >>> common/sdr_pkg.sv
`include "sdr_consts.svh"

package sdr_pkg;

  typedef enum logic [1:0] {
    st_run  = 2'b00,
    st_hold = 2'b01,
    st_wait = 2'b10
  } sdr_state_type;

  typedef struct packed {
    logic [`SDR_ADDR_W-1:0] addr;
    logic [`SDR_DATA_W-1:0] wdata;
    logic                   wr;
    logic                   rd;
  } sdr_bus_req_type;

  typedef struct packed {
    logic ctrl;
    logic stat;
    logic clr;
    logic en;
  } sdr_sel_type;

endpackage : sdr_pkg

// >>> rtl/sdr_act_counter.sv
`include "sdr_consts.svh"

module sdr_act_counter #(
  parameter logic [`SDR_WDT_W-1:0] LIMIT = `SDR_WDT_LIMIT
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   clear,
  input  wire logic                   run,
  output logic      [`SDR_WDT_W-1:0]  count,
  output logic                        expire
);
  import sdr_pkg::*;

  // Up counter on the oscillation clock; wraps to zero at the limit
  always_ff @(posedge core_clk) begin
    if (rst || clear) begin
      count <= '0;
    end else if (run) begin
      if (count == LIMIT) begin
        count <= '0;
      end else begin
        count <= count + `SDR_WDT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || clear) begin
      expire <= 1'b0;
    end else begin
      expire <= run && (count == LIMIT);
    end
  end

endmodule : sdr_act_counter

// >>> rtl/sdr_hold_timer.sv
`include "sdr_consts.svh"

module sdr_hold_timer (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  load,
  output logic                       done
);
  import sdr_pkg::*;

  logic [`SDR_HOLD_W-1:0] remain;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      remain <= '0;
    end else if (load) begin
      remain <= `SDR_HOLD_W'(`SDR_HOLD_CYC);
    end else if (remain != '0) begin
      remain <= remain - `SDR_HOLD_W'(1);
    end
  end

  assign done = (remain == `SDR_HOLD_W'(1));

endmodule : sdr_hold_timer

// >>> rtl/sdr_top.sv
// The implementer's own choice: strobed register access.
`include "sdr_consts.svh"

module sdr_top #(
  parameter logic [`SDR_WDT_W-1:0] WDT_LIMIT = `SDR_WDT_LIMIT
) (
  input  wire logic                            core_clk,
  input  wire logic                            rst,
  input  wire sdr_pkg::sdr_bus_req_type        bus_req,
  output logic      [`SDR_DATA_W-1:0]          rdata,
  input  wire logic                            supply_low,
  input  wire logic                            stop_mode,
  output logic                                 internal_reset,
  output logic                                 stop_wake,
  output logic                                 irq
);
  import sdr_pkg::*;

  sdr_state_type             state;
  sdr_state_type             next_state;
  sdr_sel_type               sel;
  logic                      supply_drop_flag;
  logic                      wdt_flag;
  logic [`SDR_IRQ_W-1:0]     irq_stat;
  logic [`SDR_IRQ_W-1:0]     irq_en;
  logic [`SDR_IRQ_W-1:0]     irq_evt;
  logic [`SDR_IRQ_W-1:0]     next_irq_stat;
  logic [`SDR_WDT_W-1:0]     wdt_count;
  logic                      wdt_expire;
  logic                      wdt_clear;
  logic                      wdt_run;
  logic                      wdt_half_d;
  logic                      hold_load;
  logic                      hold_done;
  logic                      ctrl_wr;

  // Halfway mark of the interval; the MSB rise for the full-size limit
  localparam logic [`SDR_WDT_W-1:0] WDT_HALF =
    (WDT_LIMIT >> 1) + `SDR_WDT_W'(1);

  // Address decode shared by the write and read paths
  function automatic sdr_sel_type reg_sel(
    input logic [`SDR_ADDR_W-1:0] addr
  );
    sdr_sel_type s;
    s      = '0;
    s.ctrl = (addr == `SDR_OFS_CTRL);
    s.stat = (addr == `SDR_OFS_STAT);
    s.clr  = (addr == `SDR_OFS_CLR);
    s.en   = (addr == `SDR_OFS_EN);
    return s;
  endfunction : reg_sel

  assign sel     = reg_sel(bus_req.addr);
  assign ctrl_wr = bus_req.wr && sel.ctrl;

  // Software kick, or restart of the interval while the chip is in reset
  assign wdt_clear = (ctrl_wr && bus_req.wdata[`SDR_BIT_WDT_CLR])
                     || internal_reset;
  // Oscillator is stopped in stop mode, so the count freezes
  assign wdt_run   = !stop_mode;

  sdr_act_counter #(
    .LIMIT (WDT_LIMIT)
  ) u_act_counter (
    .core_clk (core_clk),
    .rst      (rst),
    .clear    (wdt_clear),
    .run      (wdt_run),
    .count    (wdt_count),
    .expire   (wdt_expire)
  );

  sdr_hold_timer u_hold_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .load     (hold_load),
    .done     (hold_done)
  );

  // Reset sequencer
  always_comb begin
    next_state = state;
    hold_load  = 1'b0;
    case (state)
      st_run: begin
        if (supply_low || wdt_expire) begin
          next_state = st_hold;
          hold_load  = 1'b1;
        end
      end
      st_hold: begin
        if (hold_done) begin
          next_state = supply_low ? st_wait : st_run;
        end
      end
      st_wait: begin
        // Reset stays on until the supply recovers, then holds once more
        if (!supply_low) begin
          next_state = st_hold;
          hold_load  = 1'b1;
        end
      end
      default: begin
        next_state = st_run;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= st_run;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      internal_reset <= 1'b0;
    end else begin
      internal_reset <= (next_state != st_run);
    end
  end

  // Detection during stop mode also ends stop mode
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stop_wake <= 1'b0;
    end else begin
      stop_wake <= stop_mode && supply_low && (state == st_run);
    end
  end

  // Status flags: the set wins over a software write of zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      supply_drop_flag <= 1'b0;
    end else if (supply_low) begin
      supply_drop_flag <= 1'b1;
    end else if (ctrl_wr && !bus_req.wdata[`SDR_BIT_SUP_FLAG]) begin
      supply_drop_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wdt_flag <= 1'b0;
    end else if (wdt_expire) begin
      wdt_flag <= 1'b1;
    end else if (ctrl_wr && !bus_req.wdata[`SDR_BIT_WDT_FLAG]) begin
      wdt_flag <= 1'b0;
    end
  end

  // Warning event when the count passes its halfway mark
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wdt_half_d <= 1'b0;
    end else begin
      wdt_half_d <= (wdt_count == WDT_HALF);
    end
  end

  always_comb begin
    irq_evt                = '0;
    irq_evt[`SDR_IRQ_SUP]  = supply_low && (state == st_run);
    irq_evt[`SDR_IRQ_WDT]  = wdt_expire;
    irq_evt[`SDR_IRQ_WARN] = (wdt_count == WDT_HALF) && !wdt_half_d;
  end

  // Each status bit: set by its event, cleared by writing one
  generate
    for (genvar i = 0; i < `SDR_IRQ_W; i++) begin : g_stat
      always_comb begin
        if (irq_evt[i]) begin
          next_irq_stat[i] = 1'b1;
        end else if (bus_req.wr && sel.clr && bus_req.wdata[i]) begin
          next_irq_stat[i] = 1'b0;
        end else begin
          next_irq_stat[i] = irq_stat[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= next_irq_stat;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_en <= '0;
    end else if (bus_req.wr && sel.en) begin
      irq_en <= bus_req.wdata[`SDR_IRQ_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_irq_stat & next_irq_en());
    end
  end

  function automatic logic [`SDR_IRQ_W-1:0] next_irq_en();
    if (bus_req.wr && sel.en) begin
      return bus_req.wdata[`SDR_IRQ_W-1:0];
    end
    return irq_en;
  endfunction : next_irq_en

  // Read data stands for exactly one cycle after the read strobe
  always_ff @(posedge core_clk) begin
    if (rst || !bus_req.rd) begin
      rdata <= '0;
    end else begin
      rdata <= '0;
      if (sel.ctrl) begin
        rdata[`SDR_BIT_SUP_FLAG]           <= supply_drop_flag;
        rdata[`SDR_BIT_WDT_FLAG]           <= wdt_flag;
        rdata[`SDR_RSV_HI:`SDR_RSV_LO]     <= `SDR_RSV_VALUE;
      end else if (sel.stat) begin
        rdata[`SDR_IRQ_W-1:0] <= irq_stat;
      end else if (sel.en) begin
        rdata[`SDR_IRQ_W-1:0] <= irq_en;
      end
    end
  end

  // Checks
  a_flag_on_drop: assert property (
    @(posedge core_clk) disable iff (rst)
    supply_low |=> supply_drop_flag && internal_reset
  ) else $error("supply drop did not set flag and reset");

  a_count_step: assert property (
    @(posedge core_clk) disable iff (rst)
    (wdt_run && !wdt_clear && wdt_count != WDT_LIMIT)
      |=> wdt_count == $past(wdt_count) + `SDR_WDT_W'(1)
  ) else $error("watchdog counter did not advance by one");

  a_expire_reset: assert property (
    @(posedge core_clk) disable iff (rst)
    (wdt_expire && state == st_run) |=> internal_reset
  ) else $error("watchdog expiry did not raise reset");

  a_expire_when_full: assert property (
    @(posedge core_clk) disable iff (rst)
    (wdt_run && !wdt_clear && wdt_count == WDT_LIMIT) |=> wdt_expire
  ) else $error("counter reached limit without expiry");

  a_stop_wake: assert property (
    @(posedge core_clk) disable iff (rst)
    (stop_mode && supply_low && state == st_run)
      |=> stop_wake && internal_reset
  ) else $error("drop in stop mode did not wake and reset");

  a_clear_zero: assert property (
    @(posedge core_clk) disable iff (rst)
    (ctrl_wr && bus_req.wdata[`SDR_BIT_WDT_CLR]) |=> wdt_count == '0
  ) else $error("watchdog clear did not zero the counter");

  a_hold_min: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(internal_reset) |-> internal_reset [*8]
  ) else $error("internal reset pulse too short");

  a_irq_level: assert property (
    @(posedge core_clk) disable iff (rst)
    ##1 (irq == |(irq_stat & irq_en))
  ) else $error("interrupt output disagrees with status");

  c_supply_drop: cover property (
    @(posedge core_clk) disable iff (rst)
    $rose(supply_low) ##1 internal_reset
  );

  c_wdt_expire: cover property (
    @(posedge core_clk) disable iff (rst)
    wdt_expire ##1 internal_reset
  );

  c_stop_wake: cover property (
    @(posedge core_clk) disable iff (rst)
    stop_wake
  );

  c_kick: cover property (
    @(posedge core_clk) disable iff (rst)
    ctrl_wr && bus_req.wdata[`SDR_BIT_WDT_CLR] && wdt_count != '0
  );

  c_half_mark: cover property (
    @(posedge core_clk) disable iff (rst)
    irq_evt[`SDR_IRQ_WARN]
  );

endmodule : sdr_top

// >>> verif/sdr_top_test.sv
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); \
  end \
end

module sdr_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sdr_pkg::*;

  typedef struct {
    logic       do_wr;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } sdr_row_type;

  logic            core_clk;
  logic            rst;
  logic            supply_low;
  logic            stop_mode;
  sdr_bus_req_type bus_req;
  logic [7:0]      rdata;
  logic            internal_reset;
  logic            stop_wake;
  logic            irq;
  logic [7:0]      v;
  logic            seen;
  int              failures = 0;
  int              samples_checked = 0;
  int              cycles = 0;
  int              n;
  int              rise_at = 0;

  // Reset reads, then write/read pairs; 0x5A is unmapped
  sdr_row_type rows [8] = '{
    '{1'b0, 8'h6E, 8'h00, 8'h38}, '{1'b0, 8'h70, 8'h00, 8'h00},
    '{1'b0, 8'h72, 8'h00, 8'h00}, '{1'b0, 8'h5A, 8'h00, 8'h00},
    '{1'b1, 8'h72, 8'h07, 8'h07}, '{1'b1, 8'h5A, 8'hFF, 8'h00},
    '{1'b1, 8'h72, 8'h00, 8'h00}, '{1'b1, 8'h6E, 8'hC0, 8'h38}};

  sdr_top #(
    .WDT_LIMIT (20'h0003F)
  ) u_sdr_top (
    .core_clk       (core_clk),
    .rst            (rst),
    .bus_req        (bus_req),
    .rdata          (rdata),
    .supply_low     (supply_low),
    .stop_mode      (stop_mode),
    .internal_reset (internal_reset),
    .stop_wake      (stop_wake),
    .irq            (irq)
  );

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic wrap_up;
    $display("checked=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      wrap_up();
    end
  end

  // Cycle count at the edge that raises internal reset
  always @(posedge core_clk) begin
    if (internal_reset !== 1'b1) rise_at <= cycles + 1;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  // One-cycle low-supply indication, checked just after it is taken
  task automatic drop(input logic stopped);
    @(posedge core_clk);
    supply_low <= 1'b1;
    @(posedge core_clk);
    supply_low <= 1'b0;
    #1;
    `CHK(internal_reset, 1'b1)
    `CHK(stop_wake, stopped)
  endtask : drop

  task automatic wait_release;
    n = 0;
    while (internal_reset === 1'b1 && n < 100) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    `CHK(cycles - rise_at, 25)
  endtask : wait_release

  initial begin
    rst = 1'b1;
    supply_low = 1'b0;
    stop_mode = 1'b0;
    bus_req = '0;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].do_wr) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      `CHK(v, rows[i].e)
    end
    // Timely kicks keep the chip out of reset
    seen = 1'b0;
    repeat (4) begin
      wr(8'h6E, 8'h01);
      repeat (50) begin
        @(posedge core_clk);
        #1;
        seen |= internal_reset;
      end
    end
    `CHK(seen, 1'b0)
    wr(8'h72, 8'h01);
    wr(8'h6E, 8'h01);
    n = 0;
    while (internal_reset !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    `CHK(n, 65)
    rd(8'h70, v);
    `CHK(v, 8'h06)
    `CHK(irq, 1'b0)
    wr(8'h72, 8'h03);
    rd(8'h6E, v);
    `CHK(v, 8'h78)
    `CHK(irq, 1'b1)
    wait_release();
    wr(8'h6E, 8'h01);
    wr(8'h71, 8'h06);
    rd(8'h6E, v);
    `CHK(v, 8'h38)
    `CHK(irq, 1'b0)
    // Drop in run mode
    drop(1'b0);
    wait_release();
    rd(8'h6E, v);
    `CHK(v, 8'hB8)
    rd(8'h70, v);
    `CHK(v, 8'h01)
    `CHK(irq, 1'b1)
    wr(8'h6E, 8'h01);
    wr(8'h71, 8'h01);
    rd(8'h70, v);
    `CHK(v, 8'h00)
    `CHK(irq, 1'b0)
    // Stop mode: counter frozen, drop still wakes through reset
    @(posedge core_clk);
    stop_mode <= 1'b1;
    seen = 1'b0;
    repeat (100) begin
      @(posedge core_clk);
      #1;
      seen |= internal_reset;
    end
    `CHK(seen, 1'b0)
    drop(1'b1);
    @(posedge core_clk);
    stop_mode <= 1'b0;
    #1;
    `CHK(stop_wake, 1'b0)
    wait_release();
    rd(8'h6E, v);
    `CHK(v, 8'hB8)
    // Mid-run reset clears the flags, the enables and every output
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    `CHK({internal_reset, stop_wake, irq, rdata}, 11'h000)
    rd(8'h6E, v);
    `CHK(v, 8'h38)
    rd(8'h72, v);
    `CHK(v, 8'h00)
    wrap_up();
  end
endmodule : sdr_top_test
